// ### hdl/sbcrsc_defines.svh
// Offsets, field positions, reset values and timing counts
`ifndef SBCRSC_DEFINES_SVH
`define SBCRSC_DEFINES_SVH
`define SBCRSC_OFF_REG_CTRL 12'h040
`define SBCRSC_OFF_SUPPLY_STATUS 12'h06c
`define SBCRSC_OFF_STARTUP_CTRL 12'h1cc
`define SBCRSC_OFF_MODE_STATUS 12'h200
`define SBCRSC_OFF_EVENT_STATUS 12'h204
`define SBCRSC_OFF_EVENT_EN 12'h208
`define SBCRSC_IDX_REG_CTRL 8'h10
`define SBCRSC_IDX_SUPPLY_STATUS 8'h1b
`define SBCRSC_IDX_STARTUP_CTRL 8'h73
`define SBCRSC_IDX_MODE_STATUS 8'h80
`define SBCRSC_IDX_EVENT_STATUS 8'h81
`define SBCRSC_IDX_EVENT_EN 8'h82
`define SBCRSC_RC_SEC_LSB 0
`define SBCRSC_RC_THR_LSB 2
`define SBCRSC_RC_DISS_BIT 4
`define SBCRSC_SU_SEC_BIT 3
`define SBCRSC_SU_RLEN_LSB 4
`define SBCRSC_SS_SEC_LSB 2
`define SBCRSC_SS_MAIN_BIT 0
`define SBCRSC_EV_PO_BIT 0
`define SBCRSC_EV_OTW_BIT 1
`define SBCRSC_EV_UV_BIT 2
`define SBCRSC_SEC_OFF 2'h0
`define SBCRSC_SEC_ON 2'h3
`define SBCRSC_RLEN_SHORTEST 2'h3
`define SBCRSC_CLK_PERIOD_NS 5
`define SBCRSC_RST_LEN0_US 20
`define SBCRSC_RST_LEN1_US 10
`define SBCRSC_RST_LEN2_US 3
`define SBCRSC_RST_LEN3_US 1
`define SBCRSC_STARTUP_US 100
`define SBCRSC_CYC(us) (((us) * 1000 + `SBCRSC_CLK_PERIOD_NS - 1) / `SBCRSC_CLK_PERIOD_NS)
`define SBCRSC_RST_CYC0 `SBCRSC_CYC(`SBCRSC_RST_LEN0_US)
`define SBCRSC_RST_CYC1 `SBCRSC_CYC(`SBCRSC_RST_LEN1_US)
`define SBCRSC_RST_CYC2 `SBCRSC_CYC(`SBCRSC_RST_LEN2_US)
`define SBCRSC_RST_CYC3 `SBCRSC_CYC(`SBCRSC_RST_LEN3_US)
`define SBCRSC_STARTUP_CYC `SBCRSC_CYC(`SBCRSC_STARTUP_US)
`endif

// ### hdl/sbcrsc_pkg.sv
// Types shared by the reset and supply control block
package sbcrsc_pkg;
  typedef enum logic [5:0] {
    SBCRSC_OFF = 6'b000001,
    SBCRSC_RESET = 6'b000010,
    SBCRSC_STANDBY = 6'b000100,
    SBCRSC_FNORMAL = 6'b001000,
    SBCRSC_OVERTEMP = 6'b010000,
    SBCRSC_OPER = 6'b100000
  } sbcrsc_mode_t;

  typedef enum logic [3:0] {
    SBCRSC_SRC_NONE = 4'h0, SBCRSC_SRC_POWER_ON = 4'h1,
    SBCRSC_SRC_OVERTEMP = 4'h2, SBCRSC_SRC_MAIN_UV = 4'h3,
    SBCRSC_SRC_EXTERNAL = 4'h4
  } sbcrsc_src_t;

  // Analog monitor levels, all synchronous to pclk
  typedef struct packed {
    logic bat_below_off;
    logic bat_above_on;
    logic temp_above_act;
    logic temp_below_rel;
    logic temp_above_warn;
    logic main_below_60;
    logic main_below_70;
    logic main_below_80;
    logic main_below_90;
    logic sleep_active;
  } sbcrsc_mon_t;

  // Reset request from other logic of the chip
  typedef struct packed {
    logic req;
    logic [3:0] cause;
  } sbcrsc_rstreq_t;

  // Regulator and transceiver enables
  typedef struct packed {
    logic main_reg_on;
    logic [1:0] sec_reg_ctrl;
    logic can_tx_on;
    logic pass_drive_on;
    logic dissipation_share_ctrl;
  } sbcrsc_supply_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } sbcrsc_apb_rsp_t;
endpackage

// ### hdl/sbcrsc_timer.sv
// Reload-and-count-down timer for timed mode dwell
`timescale 1ns/1ps
module sbcrsc_timer import sbcrsc_pkg::*; (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Control
  input wire logic load,
  input wire logic [19:0] length,
  input wire logic run,
  // Result
  output logic done
);
  typedef struct packed {
    logic [19:0] cnt;
    logic done;
  } sbcrsc_tmr_t;
  sbcrsc_tmr_t s_q, s_d;

  always_comb begin
    s_d = s_q;
    if (load) begin
      s_d.cnt = length;
      s_d.done = 1'b0;
    end else if (run && s_q.cnt != 20'h0) begin
      s_d.cnt = s_q.cnt - 20'h1;
    end else if (run) begin
      s_d.done = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign done = s_q.done;
endmodule

// ### hdl/sbcrsc_core.sv
// Reset, thermal and supply control with APB register access
// Contract
// - Any system reset enters Reset mode, then Standby or Forced Normal.
// - Record the cause of each reset, up to twelve causes.
// - Reset with main undervoltage is cold; length from the length field.
// - Reset without main undervoltage is warm; always shortest length 11. Code also makes power-on, overtemp-release and in-sleep resets cold.
// - Start-up bit 3 loads secondary control 00 when 0, 11 when 1.
// - Temperature checked in every mode except Sleep and Off.
// - Over activation threshold: Overtemp mode, all supplies and drives off.
// - Below release threshold: leave Overtemp via Reset into Standby.
// - Above warning threshold: set warning status and latch warning event.
// - Battery below power-off threshold enters Off mode.
// - Battery above power-on: wait start-up, go to Reset, set event.
// - Control bit chooses dissipation sharing with external transistor.
// - Main output below selected 60/70/80/90 % threshold raises reset.
// - Threshold field loaded at power-up from non-volatile default.
// - Main below 90 % latches warning event when its enable is 1.
// - Live status bit shows main regulator above or below 90 %.
// - Secondary regulator off until enabled; needed for CAN transmit.
// - Secondary control loaded at power-on from non-volatile bit.
// - Secondary or off-board regulator state readable in supply status.
//
// Implementation choice: register access over APB.
`timescale 1ns/1ps
`include "sbcrsc_defines.svh"
module sbcrsc_core import sbcrsc_pkg::*; (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Non-volatile settings
  input wire logic nv_sec_startup,
  input wire logic [1:0] nv_thresh_default,
  input wire logic nv_forced_normal,
  // Monitors and reset requests
  input wire sbcrsc_mon_t mon,
  input wire sbcrsc_rstreq_t rst_req,
  input wire logic sec_reg_good,
  input wire logic go_operate,
  // Results
  output sbcrsc_supply_t supply,
  output sbcrsc_mode_t mode,
  output logic [3:0] reset_source
);
  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  typedef struct packed {
    sbcrsc_mode_t mode;
    logic [3:0] src;
    logic cold;
    logic powered;
    logic [1:0] rlen;
    logic sec_startup;
    logic [1:0] sec_ctrl;
    logic [1:0] thresh;
    logic diss;
    logic uv_en;
    logic ev_po;
    logic ev_otw;
    logic ev_uv;
    logic otw_status;
    logic main_ok90;
    logic warn_prev;
    logic uv_prev;
    sbcrsc_supply_t sup;
    sbcrsc_apb_rsp_t rsp;
  } sbcrsc_state_t;
  sbcrsc_state_t s_q, s_d;

  logic tmr_load;
  logic tmr_run;
  logic [19:0] tmr_len;
  logic tmr_done;

  // ------------------------------------------------------------
  // Decoding
  // ------------------------------------------------------------
  function automatic logic [19:0] rst_cycles(input logic [1:0] sel);
    logic [19:0] c;
    c = 20'(`SBCRSC_RST_CYC3);
    unique case (sel)
      2'h0: c = 20'(`SBCRSC_RST_CYC0);
      2'h1: c = 20'(`SBCRSC_RST_CYC1);
      2'h2: c = 20'(`SBCRSC_RST_CYC2);
      2'h3: c = 20'(`SBCRSC_RST_CYC3);
    endcase
    return c;
  endfunction

  function automatic logic below_thresh(input logic [1:0] sel,
                                        input sbcrsc_mon_t m);
    logic b;
    b = m.main_below_90;
    unique case (sel)
      2'h0: b = m.main_below_60;
      2'h1: b = m.main_below_70;
      2'h2: b = m.main_below_80;
      2'h3: b = m.main_below_90;
    endcase
    return b;
  endfunction

  function automatic logic [7:0] reg_index(input logic [11:0] a);
    return a[9:2];
  endfunction

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  logic temp_live;
  logic do_reset;
  logic [3:0] cause;
  logic uv_now;
  logic acc;
  logic [31:0] rd;
  logic hit;
  logic cold_src;
  logic [2:0] ev_set;

  always_comb begin
    s_d = s_q;
    tmr_load = 1'b0;
    tmr_run = 1'b0;
    tmr_len = rst_cycles(s_q.rlen);
    do_reset = 1'b0;
    cold_src = 1'b0;
    ev_set = 3'h0;
    cause = 4'(SBCRSC_SRC_NONE);
    uv_now = below_thresh(s_q.thresh, mon);
    temp_live = s_q.mode != SBCRSC_OFF && !mon.sleep_active;

    // ----------------------------------------------------------
    // One-shot power-up load of non-volatile defaults
    // ----------------------------------------------------------
    if (!s_q.powered) begin
      s_d.powered = 1'b1;
      s_d.thresh = nv_thresh_default;
      s_d.sec_startup = nv_sec_startup;
      s_d.sec_ctrl = nv_sec_startup ? `SBCRSC_SEC_ON
                                    : `SBCRSC_SEC_OFF;
      tmr_load = 1'b1;
      tmr_len = 20'(`SBCRSC_STARTUP_CYC);
    end

    // ----------------------------------------------------------
    // Warning and live status
    // ----------------------------------------------------------
    s_d.main_ok90 = !mon.main_below_90;
    s_d.uv_prev = mon.main_below_90;
    if (mon.main_below_90 && !s_q.uv_prev && s_q.uv_en) begin
      s_d.ev_uv = 1'b1;
      ev_set[`SBCRSC_EV_UV_BIT] = 1'b1;
    end
    s_d.otw_status = temp_live && mon.temp_above_warn;
    s_d.warn_prev = temp_live && mon.temp_above_warn;
    if (temp_live && mon.temp_above_warn && !s_q.warn_prev) begin
      s_d.ev_otw = 1'b1;
      ev_set[`SBCRSC_EV_OTW_BIT] = 1'b1;
    end

    // ----------------------------------------------------------
    // Mode sequencing
    // ----------------------------------------------------------
    unique case (s_q.mode)
      SBCRSC_OFF: begin
        tmr_run = s_q.powered && mon.bat_above_on;
        if (!mon.bat_above_on && s_q.powered) begin
          tmr_load = 1'b1;
          tmr_len = 20'(`SBCRSC_STARTUP_CYC);
        end else if (s_q.powered && tmr_done && !tmr_load) begin
          s_d.ev_po = 1'b1;
          ev_set[`SBCRSC_EV_PO_BIT] = 1'b1;
          do_reset = 1'b1;
          cold_src = 1'b1;
          cause = 4'(SBCRSC_SRC_POWER_ON);
        end
      end
      SBCRSC_OVERTEMP: begin
        if (mon.temp_below_rel) begin
          do_reset = 1'b1;
          cold_src = 1'b1;
          cause = 4'(SBCRSC_SRC_OVERTEMP);
        end
      end
      SBCRSC_RESET: begin
        tmr_run = 1'b1;
        if (uv_now) begin
          s_d.cold = 1'b1;
          tmr_load = 1'b1;
          tmr_len = rst_cycles(s_q.rlen);
        end else if (tmr_done) begin
          s_d.mode = (nv_forced_normal && !s_q.cold) ||
                     (nv_forced_normal && s_q.src != 4'(SBCRSC_SRC_OVERTEMP))
                     ? SBCRSC_FNORMAL : SBCRSC_STANDBY;
        end
      end
      SBCRSC_STANDBY, SBCRSC_FNORMAL, SBCRSC_OPER: begin
        if (s_q.mode == SBCRSC_STANDBY && go_operate) begin
          s_d.mode = SBCRSC_OPER;
        end
        if (uv_now) begin
          do_reset = 1'b1;
          cold_src = 1'b1;
          cause = 4'(SBCRSC_SRC_MAIN_UV);
        end else if (rst_req.req) begin
          do_reset = 1'b1;
          cause = rst_req.cause;
        end
      end
      default: s_d.mode = SBCRSC_OFF;
    endcase

    // ----------------------------------------------------------
    // Reset entry and overriding events
    // ----------------------------------------------------------
    // Cold causes are flagged where they arise, never by a request code
    if (do_reset) begin
      s_d.mode = SBCRSC_RESET;
      s_d.src = cause;
      s_d.cold = uv_now || cold_src || mon.sleep_active;
      tmr_load = 1'b1;
      tmr_len = s_d.cold ? rst_cycles(s_q.rlen)
                         : rst_cycles(`SBCRSC_RLEN_SHORTEST);
    end
    if (temp_live && mon.temp_above_act && s_q.mode != SBCRSC_OVERTEMP) begin
      s_d.mode = SBCRSC_OVERTEMP;
      s_d.src = 4'(SBCRSC_SRC_OVERTEMP);
    end
    if (mon.bat_below_off && s_q.mode != SBCRSC_OFF) begin
      s_d.mode = SBCRSC_OFF;
      tmr_load = 1'b1;
      tmr_len = 20'(`SBCRSC_STARTUP_CYC);
    end

    // ----------------------------------------------------------
    // APB, one wait state
    // ----------------------------------------------------------
    acc = psel && penable && !s_q.rsp.pready;
    hit = 1'b1;
    rd = 32'h0;
    unique case (reg_index(paddr))
      `SBCRSC_IDX_REG_CTRL: begin
        rd[`SBCRSC_RC_SEC_LSB +: 2] = s_q.sec_ctrl;
        rd[`SBCRSC_RC_THR_LSB +: 2] = s_q.thresh;
        rd[`SBCRSC_RC_DISS_BIT] = s_q.diss;
      end
      `SBCRSC_IDX_SUPPLY_STATUS: begin
        rd[`SBCRSC_SS_MAIN_BIT] = s_q.main_ok90;
        rd[`SBCRSC_SS_SEC_LSB] = s_q.sup.sec_reg_ctrl != `SBCRSC_SEC_OFF &&
                                 sec_reg_good;
      end
      `SBCRSC_IDX_STARTUP_CTRL: begin
        rd[`SBCRSC_SU_SEC_BIT] = s_q.sec_startup;
        rd[`SBCRSC_SU_RLEN_LSB +: 2] = s_q.rlen;
      end
      `SBCRSC_IDX_MODE_STATUS: begin
        rd[0] = s_q.cold;
        rd[5:1] = s_q.mode[5:1];
        rd[6] = s_q.otw_status;
        rd[10:7] = s_q.src;
      end
      `SBCRSC_IDX_EVENT_STATUS: begin
        rd[`SBCRSC_EV_PO_BIT] = s_q.ev_po;
        rd[`SBCRSC_EV_OTW_BIT] = s_q.ev_otw;
        rd[`SBCRSC_EV_UV_BIT] = s_q.ev_uv;
      end
      `SBCRSC_IDX_EVENT_EN: rd[0] = s_q.uv_en;
      default: hit = 1'b0;
    endcase
    s_d.rsp.pready = acc;
    s_d.rsp.pslverr = acc && !hit;
    s_d.rsp.prdata = (acc && !pwrite) ? rd : 32'h0;
    if (acc && pwrite && hit) begin
      unique case (reg_index(paddr))
        `SBCRSC_IDX_REG_CTRL: begin
          s_d.sec_ctrl = pwdata[`SBCRSC_RC_SEC_LSB +: 2];
          s_d.thresh = pwdata[`SBCRSC_RC_THR_LSB +: 2];
          s_d.diss = pwdata[`SBCRSC_RC_DISS_BIT];
        end
        `SBCRSC_IDX_STARTUP_CTRL: begin
          s_d.sec_startup = pwdata[`SBCRSC_SU_SEC_BIT];
          s_d.rlen = pwdata[`SBCRSC_SU_RLEN_LSB +: 2];
        end
        `SBCRSC_IDX_EVENT_STATUS: begin
          // Hardware set wins over a write-one clear in the same cycle
          s_d.ev_po = (s_q.ev_po & ~pwdata[`SBCRSC_EV_PO_BIT]) |
                      ev_set[`SBCRSC_EV_PO_BIT];
          s_d.ev_otw = (s_q.ev_otw & ~pwdata[`SBCRSC_EV_OTW_BIT]) |
                       ev_set[`SBCRSC_EV_OTW_BIT];
          s_d.ev_uv = (s_q.ev_uv & ~pwdata[`SBCRSC_EV_UV_BIT]) |
                      ev_set[`SBCRSC_EV_UV_BIT];
        end
        `SBCRSC_IDX_EVENT_EN: s_d.uv_en = pwdata[0];
        default: s_d.uv_en = s_q.uv_en;
      endcase
    end

    // ----------------------------------------------------------
    // Supply outputs follow the mode
    // ----------------------------------------------------------
    s_d.sup.main_reg_on = s_d.mode != SBCRSC_OVERTEMP;
    s_d.sup.pass_drive_on = s_d.mode != SBCRSC_OVERTEMP && s_d.diss;
    s_d.sup.dissipation_share_ctrl = s_d.diss;
    s_d.sup.sec_reg_ctrl = s_d.mode == SBCRSC_OVERTEMP ? `SBCRSC_SEC_OFF
                                                      : s_d.sec_ctrl;
    s_d.sup.can_tx_on = s_d.mode != SBCRSC_OVERTEMP &&
                        s_d.sec_ctrl != `SBCRSC_SEC_OFF;
  end

  // ------------------------------------------------------------
  // Registers and timer
  // ------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
      s_q.mode <= SBCRSC_OFF;
    end else begin
      s_q <= s_d;
    end
  end

  // Reset dwell must never end early, so the count reloads on every entry
  sbcrsc_timer u_timer (
    .pclk(pclk),
    .presetn(presetn),
    .load(tmr_load),
    .length(tmr_len),
    .run(tmr_run),
    .done(tmr_done)
  );

  assign prdata = s_q.rsp.prdata;
  assign pready = s_q.rsp.pready;
  assign pslverr = s_q.rsp.pslverr;
  assign supply = s_q.sup;
  assign mode = s_q.mode;
  assign reset_source = s_q.src;
endmodule

// ### dv/sbcrsc_properties.sv
// Checker for the reset and supply control block
`timescale 1ns/1ps
`include "sbcrsc_defines.svh"
module sbcrsc_properties import sbcrsc_pkg::*; (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Block
  input wire sbcrsc_mon_t mon,
  input wire sbcrsc_supply_t supply,
  input wire sbcrsc_mode_t mode
);
  // One cycle of slack for the registered mode update
  localparam int MIN_RST = `SBCRSC_RST_CYC3 - 1;
  logic [15:0] rst_cnt_q;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      rst_cnt_q <= 16'h0;
    else
      rst_cnt_q <= (mode == SBCRSC_RESET) ? rst_cnt_q + 16'h1 : 16'h0;
  end
  a_one_wait: assert property (
    psel && penable && !pready |=> pready)
    else $error("pready missing after access phase");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready held over one cycle");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_ot_entry: assert property (
    mon.temp_above_act && !mon.sleep_active && !mon.bat_below_off &&
    mode inside {SBCRSC_STANDBY, SBCRSC_OPER, SBCRSC_FNORMAL}
    |-> ##[1:3] mode == SBCRSC_OVERTEMP)
    else $error("overtemp mode not entered");
  a_ot_off: assert property (
    mode == SBCRSC_OVERTEMP && $past(mode) == SBCRSC_OVERTEMP
    |-> !supply.main_reg_on && supply.sec_reg_ctrl == 2'h0 &&
    !supply.can_tx_on && !supply.pass_drive_on)
    else $error("supply left on in overtemp");
  a_sleep_ignore: assert property (
    mon.sleep_active && mode != SBCRSC_OVERTEMP
    |=> mode != SBCRSC_OVERTEMP)
    else $error("temperature acted on in sleep");
  a_off_entry: assert property (
    mon.bat_below_off |-> ##[1:3] mode == SBCRSC_OFF)
    else $error("off mode not entered");
  a_reset_exit: assert property (
    $past(mode) == SBCRSC_RESET && mode != SBCRSC_RESET |->
    mode inside {SBCRSC_STANDBY, SBCRSC_FNORMAL, SBCRSC_OFF,
    SBCRSC_OVERTEMP})
    else $error("reset mode left to a wrong mode");
  a_reset_min: assert property (
    $past(mode) == SBCRSC_RESET &&
    mode inside {SBCRSC_STANDBY, SBCRSC_FNORMAL}
    |-> rst_cnt_q >= MIN_RST)
    else $error("reset mode left too early");
  a_main_status: assert property (
    pready && psel && !pwrite && paddr == `SBCRSC_OFF_SUPPLY_STATUS &&
    $past(mon.main_below_90) == mon.main_below_90 &&
    $past(mon.main_below_90, 3) == mon.main_below_90
    |-> prdata[0] == !mon.main_below_90)
    else $error("main level status wrong");
endmodule
bind sbcrsc_core sbcrsc_properties u_props (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .prdata, .pready,
  .pslverr, .mon, .supply, .mode
);

// ### dv/sbcrsc_host.sv
// Microcontroller model: APB master of the register interface
`timescale 1ns/1ps
module sbcrsc_host import sbcrsc_pkg::*; (
  // Clock
  input wire logic pclk,
  // APB request
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata,
  // APB answer
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h0;
    pwdata = 32'h0;
  end
  // Idle write data is inverted so a stale value never looks valid
  task automatic xfer(input logic w, input logic [11:0] a,
    input logic [31:0] d, output logic [31:0] q, output logic e);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (i == 20) testbench.time_out();
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    pwdata <= ~d;
  endtask
endmodule

// ### dv/testbench.sv
// Self-checking testbench of the reset and supply control block
`timescale 1ns/1ps
`include "sbcrsc_defines.svh"
module testbench import sbcrsc_pkg::*;;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
  logic nv_sec, nv_fn, sec_good, go_op;
  logic [1:0] nv_thr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [3:0] src;
  sbcrsc_mon_t mon;
  sbcrsc_rstreq_t rst_req;
  sbcrsc_supply_t supply;
  sbcrsc_mode_t mode;
  int n_errors, num_checks, c;
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  sbcrsc_core u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .nv_sec_startup(nv_sec),
    .nv_thresh_default(nv_thr), .nv_forced_normal(nv_fn), .mon,
    .rst_req, .sec_reg_good(sec_good), .go_operate(go_op), .supply,
    .mode, .reset_source(src));
  sbcrsc_host u_host (.pclk, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr);
  task chk(input string n, input logic [31:0] s, input logic [31:0] x);
    num_checks++;
    if (s !== x) begin
      n_errors++;
      $display("FAIL %s exp %h got %h", n, x, s);
    end
  endtask
  task wrap_up;
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task time_out;
    n_errors++;
    wrap_up();
  endtask
  task rd(input logic [11:0] a);
    u_host.xfer(1'b0, a, 32'h0, q, e);
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    u_host.xfer(1'b1, a, d, q, e);
  endtask
  task wm(input sbcrsc_mode_t m, input int b);
    c = 0;
    while (mode !== m) begin
      @(posedge pclk);
      c++;
      if (c > b) time_out();
    end
  endtask
  function logic in_len(input int n, input int x);
    return n >= x && n <= x + 6;
  endfunction
  task t_regs;
    rd(`SBCRSC_OFF_REG_CTRL);
    chk("sec default", q[1:0], 2'h0);
    chk("thr default", q[3:2], 2'h1);
    chk("sec off", supply.sec_reg_ctrl, 2'h0);
    wr(`SBCRSC_OFF_REG_CTRL, 32'h13);
    rd(`SBCRSC_OFF_SUPPLY_STATUS);
    chk("sec status", q[2], 1'b1);
    chk("sec on", supply.sec_reg_ctrl, 2'h3);
    chk("share", supply.dissipation_share_ctrl, 1'b1);
    sec_good <= 1'b0;
    rd(`SBCRSC_OFF_SUPPLY_STATUS);
    chk("sec not up", q[2], 1'b0);
    sec_good <= 1'b1;
    rd(12'h3fc);
    chk("unmapped", {q[30:0], e}, 32'h1);
    @(posedge pclk);
    nv_sec <= 1'b1;
    nv_thr <= 2'h2;
    presetn <= 1'b0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    rd(`SBCRSC_OFF_REG_CTRL);
    chk("sec nv", q[1:0], 2'h3);
    chk("thr nv", q[3:2], 2'h2);
    $display("t_regs done");
  endtask
  task t_pon;
    wr(`SBCRSC_OFF_STARTUP_CTRL, 32'h28);
    mon.bat_above_on <= 1'b1;
    wm(SBCRSC_RESET, `SBCRSC_STARTUP_CYC + 50);
    chk("start-up", c >= `SBCRSC_STARTUP_CYC - 4, 1'b1);
    wm(SBCRSC_STANDBY, 5000);
    chk("cold len", in_len(c, `SBCRSC_RST_CYC2), 1'b1);
    rd(`SBCRSC_OFF_EVENT_STATUS);
    chk("po event", q[0], 1'b1);
    rd(`SBCRSC_OFF_STARTUP_CTRL);
    chk("su bit", q[3], 1'b1);
    $display("t_pon done");
  endtask
  task t_warm;
    rst_req <= {1'b1, 4'h5};
    @(posedge pclk);
    rst_req.req <= 1'b0;
    wm(SBCRSC_RESET, 20);
    wm(SBCRSC_STANDBY, 5000);
    chk("warm len", in_len(c, `SBCRSC_RST_CYC3), 1'b1);
    chk("source", src, 4'h5);
    $display("t_warm done");
  endtask
  task t_temp;
    mon.sleep_active <= 1'b1;
    mon.temp_above_act <= 1'b1;
    mon.temp_above_warn <= 1'b1;
    repeat (8) @(posedge pclk);
    chk("sleep", mode, SBCRSC_STANDBY);
    mon.sleep_active <= 1'b0;
    wm(SBCRSC_OVERTEMP, 8);
    @(posedge pclk);
    chk("ot off", {supply.main_reg_on, supply.sec_reg_ctrl,
      supply.can_tx_on, supply.pass_drive_on}, 5'h0);
    rd(`SBCRSC_OFF_EVENT_STATUS);
    chk("otw", q[1], 1'b1);
    mon.temp_above_act <= 1'b0;
    mon.temp_above_warn <= 1'b0;
    mon.temp_below_rel <= 1'b1;
    wm(SBCRSC_RESET, 20);
    wm(SBCRSC_STANDBY, 5000);
    chk("ot len", in_len(c, `SBCRSC_RST_CYC2), 1'b1);
    mon.temp_below_rel <= 1'b0;
    $display("t_temp done");
  endtask
  task t_uv;
    mon.main_below_90 <= 1'b1;
    repeat (4) @(posedge pclk);
    rd(`SBCRSC_OFF_SUPPLY_STATUS);
    chk("main low", q[0], 1'b0);
    rd(`SBCRSC_OFF_EVENT_STATUS);
    chk("uv masked", q[2], 1'b0);
    mon.main_below_90 <= 1'b0;
    wr(`SBCRSC_OFF_EVENT_EN, 32'h1);
    rd(`SBCRSC_OFF_SUPPLY_STATUS);
    chk("main ok", q[0], 1'b1);
    mon.main_below_90 <= 1'b1;
    repeat (4) @(posedge pclk);
    rd(`SBCRSC_OFF_EVENT_STATUS);
    chk("uv event", q[2], 1'b1);
    mon.main_below_60 <= 1'b1;
    mon.main_below_70 <= 1'b1;
    mon.main_below_80 <= 1'b1;
    wm(SBCRSC_RESET, 8);
    chk("uv reset", mode, SBCRSC_RESET);
    {mon.main_below_60, mon.main_below_70} <= 2'h0;
    {mon.main_below_80, mon.main_below_90} <= 2'h0;
    wm(SBCRSC_STANDBY, 5000);
    $display("t_uv done");
  endtask
  task t_modes;
    go_op <= 1'b1;
    wm(SBCRSC_OPER, 8);
    chk("operate", mode, SBCRSC_OPER);
    go_op <= 1'b0;
    nv_fn <= 1'b1;
    rst_req <= {1'b1, 4'h7};
    @(posedge pclk);
    rst_req.req <= 1'b0;
    wm(SBCRSC_RESET, 20);
    wm(SBCRSC_FNORMAL, 5000);
    chk("fn len", in_len(c, `SBCRSC_RST_CYC3), 1'b1);
    chk("fn source", src, 4'h7);
    $display("t_modes done");
  endtask
  task t_off;
    mon.bat_above_on <= 1'b0;
    mon.bat_below_off <= 1'b1;
    wm(SBCRSC_OFF, 8);
    chk("off", mode, SBCRSC_OFF);
    $display("t_off done");
  endtask
  initial begin
    presetn = 1'b0;
    nv_sec = 1'b0;
    nv_thr = 2'h1;
    nv_fn = 1'b0;
    sec_good = 1'b1;
    go_op = 1'b0;
    mon = '0;
    rst_req = '0;
    n_errors = 0;
    num_checks = 0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_pon();
    t_warm();
    t_temp();
    t_uv();
    t_modes();
    t_off();
    wrap_up();
  end
endmodule
